// ===== bench/swp_flash_model.sv
// Behavioural flash: logs write cycles, answers reads with a given word.
// Assumes the host strobes are active low and the bench peeks at the log.
`timescale 1ns/10ps
`default_nettype none
module swp_flash_model #(
	parameter logic VGUARD_DEFAULT = 1'b1
) (
	input wire logic [swp_pkg::ADDR_W-1:0] fl_addr,
	input wire logic [15:0] fl_dq_out,
	input wire logic fl_dq_oe,
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	input wire logic [15:0] rd_word,
	output logic [15:0] dq
);
	logic [15:0] protection_mode_lock = 16'hFFFF;
	logic volatile_sector_guard = VGUARD_DEFAULT;
	logic [15:0] last_dq = 16'h0000;
	logic [swp_pkg::ADDR_W-1:0] wr_addr[$];
	logic [15:0] wr_data[$];
	time t_last = 0;
	// Write data is taken at the end of the write strobe, while address and data still stand
	always @(posedge fl_we_n) if (fl_dq_oe === 1'b1) begin
		wr_addr.push_back(fl_addr);
		wr_data.push_back(fl_dq_out);
		t_last = $time;
	end
	always @(posedge fl_oe_n) last_dq = rd_word;
	// Released bus shows the inverse of the last driven word
	always_comb dq = (!fl_ce_n && !fl_oe_n) ? rd_word : ~last_dq;
endmodule : swp_flash_model
`default_nettype wire

// ===== bench/swp_host_asserts.sv
// Port checks for the host controller: APB timing and flash strobes.
// Assumes one clock pclk and asynchronous active-low presetn.
`timescale 1ns/10ps
`default_nettype none
module swp_host_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] fl_dq_in,
	input wire logic [15:0] fl_dq_out,
	input wire logic fl_dq_oe,
	input wire logic [swp_pkg::ADDR_W-1:0] fl_addr,
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy_pulse; psel && !penable |=> pready ##1 !pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready not one pulse");
	property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("prdata outside access");
	property p_unmapped; psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	property p_strobe_excl; fl_we_n || fl_oe_n; endproperty
	a_strobe_excl: assert property (p_strobe_excl) else $error("write and read strobes");
	property p_we_ce; !fl_we_n || !fl_oe_n |-> !fl_ce_n; endproperty
	a_we_ce: assert property (p_we_ce) else $error("strobe without select");
	property p_addr_hold; !fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr) && $stable(fl_dq_out);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
	property p_read_float; !fl_oe_n |-> !fl_dq_oe; endproperty
	a_read_float: assert property (p_read_float) else $error("host drives during read");
	property p_write_drive; !fl_we_n |-> fl_dq_oe; endproperty
	a_write_drive: assert property (p_write_drive) else $error("write without data");
	property p_ce_width; $fell(fl_ce_n) |-> !fl_ce_n [*3]; endproperty
	a_ce_width: assert property (p_ce_width) else $error("select strobe too short");
	c_err: cover property (pready && pslverr);
	c_write: cover property ($fell(fl_we_n));
	c_read: cover property ($fell(fl_oe_n));
endmodule : swp_host_asserts
bind swp_host swp_host_asserts i_swp_host_asserts (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_dq_in(fl_dq_in),
	.fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
	.fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
`default_nettype wire

// ===== bench/swp_host_test.sv
// Self-checking bench for the host controller against the flash model.
// Assumes the checker is bound in from its own file.
`timescale 1ns/10ps
`default_nettype none
module swp_host_test;
	localparam logic [32:0] BIT32 = 33'h1_0000_0000;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] dq_in;
	logic [15:0] dq_out;
	logic dq_oe;
	logic [swp_pkg::ADDR_W-1:0] fa;
	logic ce_n;
	logic we_n;
	logic oe_n;
	logic [15:0] rd_word = 16'h0000;
	logic [31:0] seed = 32'h97CC;
	logic [32:0] exp_q[$];
	logic [32:0] msk_q[$];
	int failures = 0;
	int num_checks = 0;
	always #20 pclk = ~pclk;
	swp_host i_swp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fl_dq_in(dq_in), .fl_dq_out(dq_out), .fl_dq_oe(dq_oe),
		.fl_addr(fa), .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n));
	swp_flash_model i_swp_flash_model (.fl_addr(fa), .fl_dq_out(dq_out), .fl_dq_oe(dq_oe),
		.fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n), .rd_word(rd_word), .dq(dq_in));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	// Answers are compared by the monitor below, oldest note first
	always @(posedge pclk) if (pready === 1'b1) begin
		if (exp_q.size() == 0)
			check("stray pready", 33'h1, 33'h0);
		else
			check("apb answer", {pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m, output logic [31:0] r);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			failures++;
			tally_and_finish();
		end
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, 33'h0, BIT32, r);
	endtask : wr
	task automatic setpw(input logic [63:0] pw);
		wr(swp_pkg::REG_PWD_LO, pw[31:0]);
		wr(swp_pkg::REG_PWD_HI, pw[63:32]);
	endtask : setpw
	task automatic run(input swp_pkg::swp_op_t op, input logic [3:0] err);
		logic [31:0] r;
		int n;
		wr(swp_pkg::REG_CMD, {28'h0, op});
		if (op == swp_pkg::SWP_OP_GUARD_PROG)
			apb(1'b1, swp_pkg::REG_CMD, {28'h0, op}, BIT32, BIT32, r);
		n = 0;
		do begin
			apb(1'b0, swp_pkg::REG_STATUS, 32'h0, 33'h0, 33'h0, r);
			n++;
		end while (r[0] !== 1'b0 && n < 500);
		if (r[0] !== 1'b0) begin
			failures++;
			tally_and_finish();
		end
		check("status error", 33'(r[7:4]), 33'(err));
	endtask : run
	task automatic post(input int o, input int k, input logic [9:0] sec,
		input logic [63:0] pw, input logic [15:0] rw);
		int n;
		logic hit;
		logic [31:0] r;
		n = i_swp_flash_model.wr_data.size();
		hit = 1'b0;
		for (int j = k; j < n; j++)
			hit |= i_swp_flash_model.wr_addr[j][25:16] == sec;
		if (o == 2) check("sector address", 33'(hit), 33'h1);
		if (o <= 3) begin
			check("exit 0", 33'(i_swp_flash_model.wr_data[n-2]), 33'(swp_pkg::CMD_EXIT0));
			check("exit 1", 33'(i_swp_flash_model.wr_data[n-1]), 33'(swp_pkg::CMD_EXIT1));
		end
		if (o == 7 || o == 8) for (int j = 0; j < 4; j++) begin
			check("word select", 33'(i_swp_flash_model.wr_addr[n-4+j][1:0]), 33'(j));
			check("word data", 33'(i_swp_flash_model.wr_data[n-4+j]), 33'(pw[16*j+:16]));
		end
		if (o == 7) check("gap", 33'($time - i_swp_flash_model.t_last >= 1000), 33'h1);
		if (o == 9) apb(1'b0, swp_pkg::REG_RDATA, 32'h0, {17'h0, rw}, 33'h0_FFFF, r);
	endtask : post
	initial begin
		logic [31:0] r;
		logic [63:0] pw;
		int k;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h40, 32'h0, BIT32, {33{1'b1}}, r);
		apb(1'b0, swp_pkg::REG_PWD_LO, 32'h0, 33'h0, {33{1'b1}}, r);
		k = i_swp_flash_model.wr_data.size();
		wr(swp_pkg::REG_WDATA, 32'h0000_FFF9);
		run(swp_pkg::SWP_OP_LOCK_PROG, swp_pkg::ERR_BOTH_LOCK);
		check("flash writes", 33'(i_swp_flash_model.wr_data.size()), 33'(k));
		setpw({64{1'b1}});
		run(swp_pkg::SWP_OP_PWD_PROG, swp_pkg::ERR_PWD_ONE);
		for (int o = 2; o <= 11; o++) begin
			r = rnd();
			rd_word <= r[15:0];
			pw = {rnd(), r & 32'hFFFF_FFFE};
			setpw(pw);
			wr(swp_pkg::REG_ADDR, {6'h0, r[25:16], 16'h0});
			k = i_swp_flash_model.wr_data.size();
			run(swp_pkg::swp_op_t'(4'(o)), 4'h0);
			post(o, k, r[25:16], pw, r[15:0]);
		end
		wr(swp_pkg::REG_WDATA, 32'h0000_FFFB);
		k = i_swp_flash_model.wr_data.size();
		run(swp_pkg::SWP_OP_LOCK_PROG, 4'h0);
		post(1, k, 10'h0, 64'h0, 16'h0);
		apb(1'b0, swp_pkg::REG_STATUS, 32'h0, 33'h100, 33'h100, r);
		run(swp_pkg::SWP_OP_PWD_PROG, swp_pkg::ERR_PWD_LOCKED);
		tally_and_finish();
	end
endmodule : swp_host_test
`default_nettype wire

// ===== common/swp_bus_if.sv
// Interface between the sequencer and the flash bus cycle engine.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
`default_nettype none
interface swp_bus_if;
	logic req;
	logic wr;
	logic [swp_pkg::ADDR_W-1:0] addr;
	logic [15:0] wdata;
	logic done;
	logic [15:0] rdata;
	modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
	modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : swp_bus_if
`default_nettype wire

// ===== common/swp_pkg.sv
// Package for the sector write protection host controller.
// Assumes a 16-bit asynchronous parallel flash on the far side, clocked at 25 MHz here.
package swp_pkg;
	localparam int CLK_MHZ = 25;
	localparam int UNLOCK_GAP_NS = 1000;
	localparam int UNLOCK_GAP_CYC = (UNLOCK_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int BUS_PULSE_CYC = 3;
	localparam int ADDR_W = 26;
	localparam int SECTOR_LSB = 16;
	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_PWD_LO = 8'h14;
	localparam logic [7:0] REG_PWD_HI = 8'h18;
	// Lock register field positions
	localparam int LOCK_PERSIST_BIT = 1;
	localparam int LOCK_PASSWD_BIT = 2;
	// Host operation codes written into REG_CMD
	typedef enum logic [3:0] {
		SWP_OP_NONE = 4'h0,
		SWP_OP_LOCK_PROG = 4'h1,
		SWP_OP_GUARD_PROG = 4'h2,
		SWP_OP_GUARD_ERASE = 4'h3,
		SWP_OP_VGUARD_SET = 4'h4,
		SWP_OP_VGUARD_CLR = 4'h5,
		SWP_OP_FREEZE_SET = 4'h6,
		SWP_OP_PWD_UNLOCK = 4'h7,
		SWP_OP_PWD_PROG = 4'h8,
		SWP_OP_STAT_READ = 4'h9,
		SWP_OP_EXIT = 4'hA,
		SWP_OP_RAW_WRITE = 4'hB
	} swp_op_t;
	localparam logic [15:0] CMD_EXIT0 = 16'h0090;
	localparam logic [15:0] CMD_EXIT1 = 16'h0000;
	localparam logic [3:0] ERR_BOTH_LOCK = 4'h1;
	localparam logic [3:0] ERR_PWD_LOCKED = 4'h2;
	localparam logic [3:0] ERR_PWD_ONE = 4'h3;
endpackage : swp_pkg

// ===== hdl/swp_bus_eng.sv
// Flash asynchronous bus cycle engine: one write or read per request.
// Assumes the flash tolerates strobes of BUS_PULSE_CYC pclk periods.
`timescale 1ns/10ps
`default_nettype none
module swp_bus_eng (
	input wire logic pclk,
	input wire logic presetn,
	swp_bus_if.eng bus,
	input wire logic [15:0] dq_in_s,
	output logic [swp_pkg::ADDR_W-1:0] fl_addr,
	output logic [15:0] fl_dq_out,
	output logic fl_dq_oe,
	output logic fl_ce_n,
	output logic fl_we_n,
	output logic fl_oe_n
);
	typedef enum logic [1:0] {
		SWP_E_IDLE = 2'b00,
		SWP_E_STROBE = 2'b01,
		SWP_E_DONE = 2'b10
	} swp_e_t;
	swp_e_t st_r, st_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic [15:0] rd_r, rd_nxt;
	logic done_r, done_nxt;
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		rd_nxt = rd_r;
		done_nxt = 1'b0;
		case (st_r)
			SWP_E_IDLE: begin
				if (bus.req) begin
					st_nxt = SWP_E_STROBE;
					cnt_nxt = 2'(swp_pkg::BUS_PULSE_CYC - 1);
				end
			end
			SWP_E_STROBE: begin
				if (cnt_r == 2'h0) begin
					rd_nxt = dq_in_s;
					done_nxt = 1'b1;
					st_nxt = SWP_E_DONE;
				end else begin
					cnt_nxt = cnt_r - 2'h1;
				end
			end
			SWP_E_DONE: st_nxt = SWP_E_IDLE;
			default: st_nxt = SWP_E_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= SWP_E_IDLE;
			cnt_r <= 2'h0;
			rd_r <= 16'h0000;
			done_r <= 1'b0;
			fl_addr <= '0;
			fl_dq_out <= 16'h0000;
			fl_dq_oe <= 1'b0;
			fl_ce_n <= 1'b1;
			fl_we_n <= 1'b1;
			fl_oe_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			rd_r <= rd_nxt;
			done_r <= done_nxt;
			// Address and data are loaded on the same edge that the strobe falls and hold through it
			if (st_r == SWP_E_IDLE && bus.req) begin
				fl_addr <= bus.addr;
				fl_dq_out <= bus.wdata;
				fl_dq_oe <= bus.wr;
			end
			if (st_nxt == SWP_E_IDLE) begin
				fl_dq_oe <= 1'b0;
			end
			fl_ce_n <= !(st_nxt == SWP_E_STROBE);
			fl_we_n <= !(st_nxt == SWP_E_STROBE && fl_dq_oe_next(st_r, bus.req, bus.wr, fl_dq_oe));
			fl_oe_n <= !(st_nxt == SWP_E_STROBE && !fl_dq_oe_next(st_r, bus.req, bus.wr, fl_dq_oe));
		end
	end
	function automatic logic fl_dq_oe_next(swp_e_t s, logic rq, logic w, logic cur);
		fl_dq_oe_next = (s == SWP_E_IDLE && rq) ? w : cur;
	endfunction : fl_dq_oe_next
	assign bus.done = done_r;
	assign bus.rdata = rd_r;
endmodule : swp_bus_eng
`default_nettype wire

// ===== hdl/swp_host.sv
// Host controller for the flash sector write protection feature, APB slave.
// Assumes a 16-bit flash with sector select on the top address bits.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module swp_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] fl_dq_in,
	output logic [15:0] fl_dq_out,
	output logic fl_dq_oe,
	output logic [swp_pkg::ADDR_W-1:0] fl_addr,
	output logic fl_ce_n,
	output logic fl_we_n,
	output logic fl_oe_n
);
	typedef enum logic [2:0] {
		SWP_S_IDLE = 3'b000,
		SWP_S_ISSUE = 3'b001,
		SWP_S_WAIT = 3'b010,
		SWP_S_EXIT0 = 3'b011,
		SWP_S_EXIT1 = 3'b100,
		SWP_S_GAP = 3'b101
	} swp_s_t;
	swp_bus_if bus ();
	logic [15:0] dq_s;
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_sync
			swp_sync u_sync (.pclk(pclk), .presetn(presetn), .d(fl_dq_in[gi]), .q(dq_s[gi]));
		end
	endgenerate
	swp_bus_eng u_eng (
		.pclk(pclk),
		.presetn(presetn),
		.bus(bus),
		.dq_in_s(dq_s),
		.fl_addr(fl_addr),
		.fl_dq_out(fl_dq_out),
		.fl_dq_oe(fl_dq_oe),
		.fl_ce_n(fl_ce_n),
		.fl_we_n(fl_we_n),
		.fl_oe_n(fl_oe_n)
	);
	swp_s_t st_r, st_nxt;
	logic [3:0] op_r, op_nxt;
	logic [swp_pkg::ADDR_W-1:0] addr_r, addr_nxt;
	logic [15:0] wdata_r, wdata_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [31:0] pwd_lo_r, pwd_lo_nxt, pwd_hi_r, pwd_hi_nxt;
	logic [1:0] word_r, word_nxt;
	logic [5:0] gap_r, gap_nxt;
	logic [3:0] err_r, err_nxt;
	logic busy_r, busy_nxt;
	logic lock_seen_r, lock_seen_nxt;
	logic [31:0] prdata_nxt;
	logic pready_nxt, pslverr_nxt;
	logic breq, bwr;
	logic [swp_pkg::ADDR_W-1:0] baddr;
	logic [15:0] bwdata;
	logic setup, wr_cmd, last_word;
	function automatic logic [15:0] pwd_word(logic [31:0] lo, logic [31:0] hi, logic [1:0] i);
		case (i)
			2'd0: pwd_word = lo[15:0];
			2'd1: pwd_word = lo[31:16];
			2'd2: pwd_word = hi[15:0];
			default: pwd_word = hi[31:16];
		endcase
	endfunction : pwd_word
	function automatic logic is_pwd_op(logic [3:0] o);
		is_pwd_op = (o == swp_pkg::SWP_OP_PWD_UNLOCK) || (o == swp_pkg::SWP_OP_PWD_PROG);
	endfunction : is_pwd_op
	assign setup = psel && !penable;
	assign wr_cmd = setup && pwrite && (paddr == swp_pkg::REG_CMD) && !busy_r;
	assign last_word = (word_r == 2'd3) || !is_pwd_op(op_r);
	always_comb begin
		st_nxt = st_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		pwd_lo_nxt = pwd_lo_r;
		pwd_hi_nxt = pwd_hi_r;
		word_nxt = word_r;
		gap_nxt = (gap_r != 6'd0) ? gap_r - 6'd1 : 6'd0;
		err_nxt = err_r;
		busy_nxt = busy_r;
		lock_seen_nxt = lock_seen_r;
		breq = 1'b0;
		bwr = 1'b1;
		baddr = addr_r;
		bwdata = wdata_r;
		prdata_nxt = 32'h0000_0000;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		// APB slave: answers one cycle after setup
		if (setup) begin
			pready_nxt = 1'b1;
			if (pwrite) begin
				case (paddr)
					swp_pkg::REG_CMD: begin
						if (busy_r) begin
							pslverr_nxt = 1'b1;
						end
					end
					swp_pkg::REG_ADDR: addr_nxt = pwdata[swp_pkg::ADDR_W-1:0];
					swp_pkg::REG_WDATA: wdata_nxt = pwdata[15:0];
					swp_pkg::REG_PWD_LO: pwd_lo_nxt = pwdata;
					swp_pkg::REG_PWD_HI: pwd_hi_nxt = pwdata;
					default: pslverr_nxt = 1'b1;
				endcase
			end else begin
				case (paddr)
					swp_pkg::REG_ADDR: prdata_nxt = 32'(addr_r);
					swp_pkg::REG_WDATA: prdata_nxt = {16'h0000, wdata_r};
					swp_pkg::REG_STATUS: prdata_nxt = {23'h0, lock_seen_r, err_r, op_r[2:0], busy_r};
					swp_pkg::REG_RDATA: prdata_nxt = {16'h0000, rdata_r};
					swp_pkg::REG_PWD_LO, swp_pkg::REG_PWD_HI, swp_pkg::REG_CMD: prdata_nxt = 32'h0;
					default: pslverr_nxt = 1'b1;
				endcase
			end
		end
		if (wr_cmd) begin
			op_nxt = pwdata[3:0];
			word_nxt = 2'd0;
			err_nxt = 4'h0;
			busy_nxt = 1'b1;
			st_nxt = SWP_S_ISSUE;
			// Refuse both mode locks in one program
			if (pwdata[3:0] == swp_pkg::SWP_OP_LOCK_PROG &&
			    !wdata_r[swp_pkg::LOCK_PERSIST_BIT] && !wdata_r[swp_pkg::LOCK_PASSWD_BIT]) begin
				err_nxt = swp_pkg::ERR_BOTH_LOCK;
				busy_nxt = 1'b0;
				st_nxt = SWP_S_IDLE;
			end
			// Once password mode is locked no password program is sent
			if (pwdata[3:0] == swp_pkg::SWP_OP_PWD_PROG && lock_seen_r) begin
				err_nxt = swp_pkg::ERR_PWD_LOCKED;
				busy_nxt = 1'b0;
				st_nxt = SWP_S_IDLE;
			end
			// Password may only be driven from 1 to 0
			if (pwdata[3:0] == swp_pkg::SWP_OP_PWD_PROG && pwd_lo_r == 32'hFFFF_FFFF &&
			    pwd_hi_r == 32'hFFFF_FFFF) begin
				err_nxt = swp_pkg::ERR_PWD_ONE;
				busy_nxt = 1'b0;
				st_nxt = SWP_S_IDLE;
			end
		end
		case (st_r)
			SWP_S_IDLE: ;
			SWP_S_ISSUE: begin
				// Unlocks are spaced at least 1 us apart
				if (!(op_r == swp_pkg::SWP_OP_PWD_UNLOCK && gap_r != 6'd0)) begin
					breq = 1'b1;
					bwr = (op_r != swp_pkg::SWP_OP_STAT_READ);
					if (is_pwd_op(op_r)) begin
						// Only A1-A0 select the password word
						baddr = {addr_r[swp_pkg::ADDR_W-1:2], word_r};
						bwdata = pwd_word(pwd_lo_r, pwd_hi_r, word_r);
					end else begin
						// Sector select bits ride with the guard program
						baddr = addr_r;
					end
					st_nxt = SWP_S_WAIT;
				end
			end
			SWP_S_WAIT: begin
				if (bus.done) begin
					if (!bwr_is_write(op_r)) begin
						rdata_nxt = bus.rdata;
					end
					if (op_r == swp_pkg::SWP_OP_LOCK_PROG && !wdata_r[swp_pkg::LOCK_PASSWD_BIT]) begin
						lock_seen_nxt = 1'b1;
					end
					if (!last_word) begin
						word_nxt = word_r + 2'd1;
						st_nxt = SWP_S_ISSUE;
					end else if (op_r == swp_pkg::SWP_OP_PWD_UNLOCK) begin
						gap_nxt = 6'(swp_pkg::UNLOCK_GAP_CYC);
						st_nxt = SWP_S_GAP;
					end else if (op_r == swp_pkg::SWP_OP_GUARD_PROG ||
					             op_r == swp_pkg::SWP_OP_GUARD_ERASE ||
					             op_r == swp_pkg::SWP_OP_LOCK_PROG) begin
						st_nxt = SWP_S_EXIT0;
					end else begin
						busy_nxt = 1'b0;
						st_nxt = SWP_S_IDLE;
					end
				end
			end
			SWP_S_GAP: begin
				// Device needs about 1 us before the unlock takes effect
				if (gap_r == 6'd0) begin
					busy_nxt = 1'b0;
					st_nxt = SWP_S_IDLE;
				end
			end
			SWP_S_EXIT0: begin
				breq = !bus.done;
				bwdata = swp_pkg::CMD_EXIT0;
				if (bus.done) begin
					st_nxt = SWP_S_EXIT1;
				end
			end
			SWP_S_EXIT1: begin
				breq = !bus.done;
				bwdata = swp_pkg::CMD_EXIT1;
				if (bus.done) begin
					busy_nxt = 1'b0;
					st_nxt = SWP_S_IDLE;
				end
			end
			default: st_nxt = SWP_S_IDLE;
		endcase
	end
	function automatic logic bwr_is_write(logic [3:0] o);
		bwr_is_write = (o != swp_pkg::SWP_OP_STAT_READ);
	endfunction : bwr_is_write
	logic req_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_r <= 1'b0;
		end else begin
			req_r <= breq && !req_r && !bus.done;
		end
	end
	assign bus.req = req_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.wr <= 1'b0;
			bus.addr <= '0;
			bus.wdata <= 16'h0000;
		end else if (breq) begin
			bus.wr <= bwr;
			bus.addr <= baddr;
			bus.wdata <= bwdata;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= SWP_S_IDLE;
			op_r <= 4'h0;
			addr_r <= '0;
			wdata_r <= 16'hFFFF;
			rdata_r <= 16'h0000;
			pwd_lo_r <= 32'hFFFF_FFFF;
			pwd_hi_r <= 32'hFFFF_FFFF;
			word_r <= 2'd0;
			gap_r <= 6'd0;
			err_r <= 4'h0;
			busy_r <= 1'b0;
			lock_seen_r <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			pwd_lo_r <= pwd_lo_nxt;
			pwd_hi_r <= pwd_hi_nxt;
			word_r <= word_nxt;
			gap_r <= gap_nxt;
			err_r <= err_nxt;
			busy_r <= busy_nxt;
			lock_seen_r <= lock_seen_nxt;
			prdata <= prdata_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
		end
	end
endmodule : swp_host
`default_nettype wire

// ===== hdl/swp_sync.sv
// Two-flop synchroniser for a pin input.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module swp_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d,
	output logic q
);
	logic meta_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : swp_sync
`default_nettype wire
